// file: src/spons_notify.sv
`timescale 1ns/1ps
module spons_notify
  import spons_pkg::*;
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic reset,
  // slow domain edge and events
  input  wire logic slow_edge,
  input  wire logic notify_done,
  input  wire logic clear_req,
  // status out
  output logic      notify_received
);

  spons_notify_s st_r;
  spons_notify_s st_nxt;

  // ==========================================================================
  // events wait for the next slow edge
  always_comb
  begin
    st_nxt = st_r;
    if (notify_done)
      st_nxt.set_pend = 1'b1;
    if (clear_req)
      st_nxt.clr_pend = 1'b1;
    if (slow_edge)
    begin
      if (st_r.clr_pend)
        st_nxt.notify_received = 1'b0;
      if (st_r.set_pend)
        st_nxt.notify_received = 1'b1;
      st_nxt.set_pend = notify_done;
      st_nxt.clr_pend = clear_req;
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      st_r <= '{set_pend: 1'b0, clr_pend: 1'b0, notify_received: RST_NOTIFY_STS};
    else
      st_r <= st_nxt;
  end

  assign notify_received = st_r.notify_received;

endmodule

// file: src/spons_pkg.sv
package spons_pkg;

  // ==========================================================================
  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_LINK_PIN_CTL  = 6'h0e;
  localparam logic [5:0] IDX_BUS_PIN_CTL   = 6'h0f;
  localparam logic [5:0] IDX_NOTIFY_STS    = 6'h10;
  localparam logic [5:0] IDX_NOTIFY_ENABLE = 6'h11;

  // ==========================================================================
  // field positions
  localparam int BIT_CLK_RELEASE  = 2;
  localparam int BIT_LINE1_LEVEL  = 1;
  localparam int BIT_LINE0_LEVEL  = 0;
  localparam int BIT_DATA_LEVEL   = 1;
  localparam int BIT_CLK_LEVEL    = 0;
  localparam int BIT_NOTIFY       = 0;

  // ==========================================================================
  // reset values
  localparam logic       RST_CLK_RELEASE = 1'b1;
  localparam logic       RST_NOTIFY_STS  = 1'b0;
  localparam logic       RST_NOTIFY_EN   = 1'b0;
  localparam logic [7:0] RST_RDATA       = 8'h00;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic link_line0;
    logic link_line1;
    logic bus_clk;
    logic bus_data;
    logic slow_clk;
  } spons_pins_s;

  localparam int PINS_W = $bits(spons_pins_s);

  typedef struct packed {
    logic set_pend;
    logic clr_pend;
    logic notify_received;
  } spons_notify_s;

  typedef struct packed {
    logic       waitreq;
    logic [7:0] rdata;
    logic       link_clk_release;
    logic       bus_clk_release;
    logic       notify_enable;
    logic       link_line0_oe_n;
    logic       bus_clk_oe_n;
    logic       irq;
    logic       nack;
    logic       update_allow;
    logic       slow_prev;
  } spons_state_s;

  // ==========================================================================
  // register index decode
  function automatic logic [5:0] spons_index(input logic [7:0] byte_addr);
    spons_index = byte_addr[7:2];
  endfunction

endpackage

// file: src/spons_sync.sv
`timescale 1ns/1ps
module spons_sync
  import spons_pkg::*;
#(
  parameter int W = 1
)
(
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         reset,
  // asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // ==========================================================================
  // two flop chain per bit
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      always_ff @(posedge mclk or posedge reset)
      begin
        if (reset)
        begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
        end
        else
        begin
          meta_r[g] <= async_in[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  assign sync_out = sync_r;

endmodule

// file: src/spons_top.sv
// Contract
// - link clock release zero forces line0 low
// - link release one leaves line0 to logic
// - link bit1 reads line1 level
// - link bit0 read-only line0 level
// - bus release zero forces clock low
// - bus release one leaves clock alone
// - bus bit1 read-only data level
// - bus bit0 read-only clock level
// - registers reset only by resume reset
// - set notify bit on completed notify
// - write one clears, zero no effect
// - notify registers update only when clear
// - nack new notify while bit set
// - interrupt is status and enable
`timescale 1ns/1ps
module spons_top
  import spons_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // avalon-mm slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // pins and slow clock
  input  wire logic        link_line0_pin_i,
  input  wire logic        link_line1_pin_i,
  input  wire logic        bus_clk_pin_i,
  input  wire logic        bus_data_pin_i,
  input  wire logic        slow_clk,
  output logic             link_line0_pin_o,
  output logic             link_line0_pin_oe_n,
  output logic             bus_clk_pin_o,
  output logic             bus_clk_pin_oe_n,
  // link and bus engines
  input  wire logic        link_line0_drive_low,
  input  wire logic        bus_clk_drive_low,
  input  wire logic        notify_done,
  output logic             notify_nack,
  output logic             notify_update_allow,
  // interrupt
  output logic             notify_irq
);

  spons_state_s st_r;
  spons_state_s st_nxt;
  spons_pins_s  pins_async;
  spons_pins_s  pins_sync;
  logic         slow_edge;
  logic         bus_req;
  logic         bus_acc;
  logic [5:0]   idx;
  logic         clear_req;
  logic         notify_received;
  logic [7:0]   rd_val;

  // ==========================================================================
  // input synchronisers
  assign pins_async = '{link_line0: link_line0_pin_i, link_line1: link_line1_pin_i,
                        bus_clk: bus_clk_pin_i, bus_data: bus_data_pin_i, slow_clk: slow_clk};

  spons_sync #(.W(PINS_W)) u_sync
  (
    .mclk     (mclk),
    .reset    (reset),
    .async_in (pins_async),
    .sync_out (pins_sync)
  );

  assign slow_edge = pins_sync.slow_clk & ~st_r.slow_prev;

  // ==========================================================================
  // bus decode
  assign bus_req   = read | write;
  assign bus_acc   = bus_req & ~st_r.waitreq;
  assign idx       = spons_index(address);

  assign clear_req = bus_acc & write & byteenable[0] & (address[1:0] == 2'b00)
                     & (idx == IDX_NOTIFY_STS) & writedata[BIT_NOTIFY];

  // ==========================================================================
  // notify status in slow domain
  // write lands at slow edge
  spons_notify u_notify
  (
    .mclk            (mclk),
    .reset           (reset),
    .slow_edge       (slow_edge),
    .notify_done     (notify_done),
    .clear_req       (clear_req),
    .notify_received (notify_received)
  );

  // ==========================================================================
  // read mux
  always_comb
  begin
    rd_val = 8'h00;
    if (address[1:0] == 2'b00)
    begin
      unique case (idx)
        IDX_LINK_PIN_CTL:
        begin
          rd_val[BIT_CLK_RELEASE] = st_r.link_clk_release;
          rd_val[BIT_LINE1_LEVEL] = pins_sync.link_line1;
          rd_val[BIT_LINE0_LEVEL] = pins_sync.link_line0;
        end
        IDX_BUS_PIN_CTL:
        begin
          rd_val[BIT_CLK_RELEASE] = st_r.bus_clk_release;
          rd_val[BIT_DATA_LEVEL]  = pins_sync.bus_data;
          rd_val[BIT_CLK_LEVEL]   = pins_sync.bus_clk;
        end
        IDX_NOTIFY_STS:
          rd_val[BIT_NOTIFY] = notify_received;
        IDX_NOTIFY_ENABLE:
          rd_val[BIT_NOTIFY] = st_r.notify_enable;
        default:
          rd_val = 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // next state
  always_comb
  begin
    st_nxt           = st_r;
    st_nxt.slow_prev = pins_sync.slow_clk;

    // bus handshake: one wait cycle, then answer
    if (bus_acc)
      st_nxt.waitreq = 1'b1;
    else if (bus_req)
    begin
      st_nxt.waitreq = 1'b0;
      st_nxt.rdata   = read ? rd_val : 8'h00;
    end

    // register writes take effect at the answering edge
    if (bus_acc & write & byteenable[0] & (address[1:0] == 2'b00))
    begin
      unique case (idx)
        IDX_LINK_PIN_CTL:
          st_nxt.link_clk_release = writedata[BIT_CLK_RELEASE];
        IDX_BUS_PIN_CTL:
          st_nxt.bus_clk_release = writedata[BIT_CLK_RELEASE];
        IDX_NOTIFY_ENABLE:
          st_nxt.notify_enable = writedata[BIT_NOTIFY];
        default:
          st_nxt.notify_enable = st_r.notify_enable;
      endcase
    end

    st_nxt.link_line0_oe_n = ~(~st_r.link_clk_release | link_line0_drive_low);
    st_nxt.bus_clk_oe_n    = ~(~st_r.bus_clk_release | bus_clk_drive_low);

    st_nxt.irq          = notify_received & st_r.notify_enable;
    st_nxt.nack         = notify_received;
    st_nxt.update_allow = ~notify_received;
  end

  // ==========================================================================
  // state register
  // resume reset only
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      st_r.waitreq          <= 1'b1;
      st_r.rdata            <= RST_RDATA;
      st_r.link_clk_release <= RST_CLK_RELEASE;
      st_r.bus_clk_release  <= RST_CLK_RELEASE;
      st_r.notify_enable    <= RST_NOTIFY_EN;
      st_r.link_line0_oe_n  <= 1'b1;
      st_r.bus_clk_oe_n     <= 1'b1;
      st_r.irq              <= 1'b0;
      st_r.nack             <= 1'b0;
      st_r.update_allow     <= 1'b1;
      st_r.slow_prev        <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  // ==========================================================================
  // outputs
  assign readdata            = {24'h000000, st_r.rdata};
  assign waitrequest         = st_r.waitreq;
  assign link_line0_pin_o    = 1'b0;
  assign link_line0_pin_oe_n = st_r.link_line0_oe_n;
  assign bus_clk_pin_o       = 1'b0;
  assign bus_clk_pin_oe_n    = st_r.bus_clk_oe_n;
  assign notify_nack         = st_r.nack;
  assign notify_update_allow = st_r.update_allow;
  assign notify_irq          = st_r.irq;

endmodule

// file: verification/spons_far.sv
`timescale 1ns/1ps
module spons_far
(
  // open-drain enables from the device
  input wire logic       link0_oe_n,
  input wire logic       bus_clk_oe_n,
  // lines pulled low by outside parties
  input wire logic [3:0] ext_low,
  // resolved levels: bus data, bus clock, link1, link0
  output logic     [3:0] lines
);
  // ==========================================================================
  // pull-ups: a line is high unless someone pulls it
  assign lines[0] = link0_oe_n & ~ext_low[0];
  assign lines[1] = ~ext_low[1];
  assign lines[2] = bus_clk_oe_n & ~ext_low[2];
  assign lines[3] = ~ext_low[3];
endmodule

// file: verification/spons_top_bench.sv
`timescale 1ns/1ps
module spons_top_bench;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        slow_clk = 1'b0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [7:0]  address = 8'h00;
  logic [31:0] writedata = 32'h0;
  logic        l0_low = 1'b0;
  logic        bc_low = 1'b0;
  logic        done = 1'b0;
  logic [3:0]  ext_low = 4'h0;
  logic [3:0]  be = 4'h1;
  logic [31:0] readdata, rd;
  logic [3:0]  lines;
  logic        waitrequest, l0_oe_n, bc_oe_n, nack, allow, irq;
  int          miscompares = 0;
  int          num_checks = 0;
  initial forever #2.5 mclk = ~mclk;
  initial forever #24 slow_clk = ~slow_clk;
  spons_top i_dut (.mclk(mclk), .reset(reset), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(be), .readdata(readdata), .waitrequest(waitrequest),
    .link_line0_pin_i(lines[0]), .link_line1_pin_i(lines[1]), .bus_clk_pin_i(lines[2]),
    .bus_data_pin_i(lines[3]), .slow_clk(slow_clk), .link_line0_pin_o(), .link_line0_pin_oe_n(l0_oe_n),
    .bus_clk_pin_o(), .bus_clk_pin_oe_n(bc_oe_n), .link_line0_drive_low(l0_low), .bus_clk_drive_low(bc_low),
    .notify_done(done), .notify_nack(nack), .notify_update_allow(allow), .notify_irq(irq));
  spons_far i_far (.link0_oe_n(l0_oe_n), .bus_clk_oe_n(bc_oe_n), .ext_low(ext_low), .lines(lines));
  // ==========================================================================
  // expectations
  function automatic logic oe_exp(input logic rel, input logic drv);
    return !(!rel || drv);
  endfunction
  function automatic logic [7:0] pin_reg(input logic rel, input logic hi, input logic lo);
    return {5'h00, rel, hi, lo};
  endfunction
  // ==========================================================================
  // tasks
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do
    begin
      @(posedge mclk);
      n++;
      if (n > 20)
      begin
        miscompares++;
        give_verdict();
      end
    end
    while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, {24'h0, e});
  endtask
  task automatic wait_nack(input logic v);
    int n;
    for (n = 0; n < 200 && nack !== v; n++)
      @(posedge mclk);
    if (nack !== v)
    begin
      miscompares++;
      give_verdict();
    end
  endtask
  // ==========================================================================
  // main sequence
  initial
  begin
    logic rl, rb, dl, db;
    int   n;
    void'($urandom(32'h74ca));
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    repeat (3) @(posedge mclk);
    rchk(8'h38, 8'h07);
    rchk(8'h3c, 8'h07);
    rchk(8'h40, 8'h00);
    rchk(8'h44, 8'h00);
    rchk(8'h80, 8'h00);
    chk({l0_oe_n, bc_oe_n, nack, allow, irq}, 5'b11010);
    bus(1'b1, 8'h39, 32'h0);
    be <= 4'h0;
    bus(1'b1, 8'h38, 32'h0);
    be <= 4'h1;
    rchk(8'h38, 8'h07);
    $display("test reset_values done");
    repeat (16)
    begin
      {rl, rb, dl, db} = 4'($urandom);
      ext_low <= 4'($urandom);
      l0_low <= dl;
      bc_low <= db;
      bus(1'b1, 8'h38, {29'h0, rl, 2'($urandom)});
      bus(1'b1, 8'h3c, {29'h0, rb, 2'($urandom)});
      repeat (4) @(posedge mclk);
      chk(l0_oe_n, oe_exp(rl, dl));
      chk(bc_oe_n, oe_exp(rb, db));
      rchk(8'h38, pin_reg(rl, lines[1], lines[0]));
      rchk(8'h3c, pin_reg(rb, lines[3], lines[2]));
    end
    ext_low <= 4'h0;
    l0_low <= 1'b0;
    bc_low <= 1'b0;
    $display("test pin_control done");
    bus(1'b1, 8'h44, 32'h1);
    done <= 1'b1;
    @(posedge mclk);
    done <= 1'b0;
    wait_nack(1'b1);
    @(posedge mclk);
    chk({irq, nack, allow}, 3'b110);
    rchk(8'h40, 8'h01);
    bus(1'b1, 8'h44, 32'h0);
    repeat (3) @(posedge mclk);
    chk(irq, 1'b0);
    bus(1'b1, 8'h44, 32'h1);
    repeat (3) @(posedge mclk);
    chk(irq, 1'b1);
    bus(1'b1, 8'h40, 32'h0);
    repeat (40) @(posedge mclk);
    rchk(8'h40, 8'h01);
    bus(1'b1, 8'h40, 32'h1);
    n = 0;
    do
    begin
      bus(1'b0, 8'h40, 32'h0);
      n++;
    end
    while (rd[0] !== 1'b0 && n < 20);
    @(posedge mclk);
    chk(rd, 32'h0);
    chk({irq, nack, allow}, 3'b001);
    $display("test notify done");
    bus(1'b1, 8'h38, 32'h0);
    bus(1'b1, 8'h3c, 32'h0);
    repeat (2) @(posedge mclk);
    chk({l0_oe_n, bc_oe_n}, 2'b00);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    chk({l0_oe_n, bc_oe_n, irq}, 3'b110);
    reset <= 1'b0;
    repeat (3) @(posedge mclk);
    rchk(8'h38, 8'h07);
    $display("test mid_reset done");
    give_verdict();
  end
  initial
  begin
    repeat (100000) @(posedge mclk);
    miscompares++;
    give_verdict();
  end
endmodule

// file: verification/spons_top_props.sv
`timescale 1ns/1ps
module spons_top_props
  import spons_pkg::*;
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        reset,
  // register bus
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // pins
  input wire logic        link_line0_pin_o,
  input wire logic        link_line0_pin_oe_n,
  input wire logic        bus_clk_pin_o,
  input wire logic        bus_clk_pin_oe_n,
  // engines and interrupt
  input wire logic        link_line0_drive_low,
  input wire logic        bus_clk_drive_low,
  input wire logic        notify_done,
  input wire logic        notify_nack,
  input wire logic        notify_update_allow,
  input wire logic        notify_irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // ==========================================================================
  // sequences
  sequence s_answer;
    !waitrequest ##1 waitrequest;
  endsequence
  sequence s_notify_seen;
    ##[1:40] notify_nack;
  endsequence
  // ==========================================================================
  // properties
  a_wait_single: assert property ((read || write) && waitrequest |=> s_answer)
    else $error("wait cycle shape");
  a_wait_cause: assert property ($fell(waitrequest) |-> $past(read || write))
    else $error("answer without request");
  a_rdata_upper: assert property (!waitrequest |-> readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_link_engine_low: assert property (link_line0_drive_low |=> !link_line0_pin_oe_n)
    else $error("link line0 not pulled");
  a_bus_engine_low: assert property (bus_clk_drive_low |=> !bus_clk_pin_oe_n)
    else $error("bus clock not pulled");
  a_pins_drive_zero: assert property (!link_line0_pin_o && !bus_clk_pin_o)
    else $error("pin value not low");
  a_nack_vs_allow: assert property (notify_nack == !notify_update_allow)
    else $error("nack and allow disagree");
  a_irq_needs_status: assert property (notify_irq |-> notify_nack)
    else $error("irq without status");
  a_notify_sets: assert property (notify_done |-> s_notify_seen)
    else $error("notify not recorded");
endmodule
bind spons_top spons_top_props i_props (.mclk, .reset, .read, .write, .readdata, .waitrequest, .link_line0_pin_o,
  .link_line0_pin_oe_n, .bus_clk_pin_o, .bus_clk_pin_oe_n, .link_line0_drive_low, .bus_clk_drive_low,
  .notify_done, .notify_nack, .notify_update_allow, .notify_irq);
